// [common/wssp_pkg.sv]
`default_nettype none
package wssp_pkg;
    // Widths of one word and of the field that picks one of the three exchange forms.
    localparam int WORD_W = 16;
    localparam int FORM_W = 2;
    // Exchange forms, chosen by which data register a write lands on.
    localparam logic [1:0] FORM_WORD = 2'h0;
    localparam logic [1:0] FORM_LONG = 2'h1;
    localparam logic [1:0] FORM_EXT = 2'h2;
    // Register selectors on the link.
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] SEL_EXT = 2'h2;
    localparam logic [1:0] SEL_RESP = 2'h3;
    // Command opcode sits in the top byte of the word-form command.
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 8;
    localparam int CNT_MSB = 7;
    localparam logic [7:0] OP_READ_PROTOCOL = 8'hFC;
    localparam logic [7:0] OP_CLEAR = 8'hFF;
    localparam logic [7:0] OP_READ_WORDS = 8'hDF;
    localparam logic [7:0] OP_WRITE_DATA = 8'hBC;
    // Capability word: bit 0 long form, bit 1 extended form.
    localparam int CAP_LONG_BIT = 0;
    localparam int CAP_EXT_BIT = 1;
    // Response register bit positions.
    localparam int RESP_WRITE_READY = 1;
    localparam int RESP_READ_READY = 2;
    localparam int RESP_ERROR_N = 3;
    localparam logic [15:0] RESP_BASE = 16'h0001;
    // Reset values of the flags.
    localparam logic WRITE_READY_RST = 1'b1;
    localparam logic READ_READY_RST = 1'b0;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
endpackage
`default_nettype wire

// [common/wssp_if.sv]
`default_nettype none
interface wssp_if;
    // One bus cycle: strobe with read or write, register select, data.
    logic strobe;
    logic write;
    logic [1:0] sel;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    logic err;
    modport servant (
        input strobe, write, sel, wdata,
        output rdata, ack, err
    );
    modport commander (
        output strobe, write, sel, wdata,
        input rdata, ack, err
    );
endinterface
`default_nettype wire

// [rtl/wssp_cmd_decode.sv]
`default_nettype none
// Splits an incoming command word into its effects for the given form.
module wssp_cmd_decode (
    input wire logic [1:0] form,
    input wire logic [15:0] cmd,
    output logic is_clear,
    output logic is_protocol,
    output logic is_read_words,
    output logic is_write_data,
    output logic [7:0] count
);
    // Word-form opcodes only count in the word form; other forms are user.
    always_comb begin
        is_clear = 1'b0;
        is_protocol = 1'b0;
        is_read_words = 1'b0;
        is_write_data = 1'b0;
        count = cmd[wssp_pkg::CNT_MSB:0];
        if (form == wssp_pkg::FORM_WORD) begin
            case (cmd[wssp_pkg::OP_MSB:wssp_pkg::OP_LSB])
                wssp_pkg::OP_CLEAR: is_clear = 1'b1;
                wssp_pkg::OP_READ_PROTOCOL: is_protocol = 1'b1;
                wssp_pkg::OP_READ_WORDS: is_read_words = 1'b1;
                wssp_pkg::OP_WRITE_DATA: is_write_data = 1'b1;
                default: is_clear = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// [rtl/wssp_servant.sv]
`default_nettype none
module wssp_servant #(
    parameter bit HAS_LONG = 1'b1,
    parameter bit HAS_EXT = 1'b1
) (
    input wire logic CLK,
    input wire logic RESET_N,
    wssp_if.servant LINK,
    output logic CMD_VALID,
    output logic [1:0] CMD_FORM,
    output logic [47:0] CMD_WORD,
    output logic CMD_IS_DATA,
    input wire logic CMD_TAKEN,
    input wire logic [15:0] OUT_WORD,
    input wire logic OUT_VALID,
    output logic OUT_TAKEN,
    output logic OUT_WANTED
);
    logic write_ready, next_write_ready;
    logic read_ready, next_read_ready;
    logic [15:0] high_hold, next_high_hold;
    logic [15:0] ext_hold, next_ext_hold;
    logic [47:0] cmd_word, next_cmd_word;
    logic [1:0] cmd_form, next_cmd_form;
    logic cmd_is_data, next_cmd_is_data;
    logic [7:0] data_left, next_data_left;
    logic [7:0] out_left, next_out_left;
    logic [15:0] rd_word, next_rd_word;
    logic cap_pending, next_cap_pending;
    logic [15:0] rdata, next_rdata;
    logic ack, next_ack, err, next_err;
    logic d_clear, d_proto, d_rdw, d_wrd;
    logic [7:0] d_count;
    logic wr_low, rd_low;
    logic [15:0] cap_word;
    logic [1:0] wr_form;

    // Capability word reports which wider forms this servant supports.
    assign cap_word = 16'(({15'h0000, HAS_EXT} << wssp_pkg::CAP_EXT_BIT)
        | ({15'h0000, HAS_LONG} << wssp_pkg::CAP_LONG_BIT));

    assign wr_low = LINK.strobe && LINK.write
        && LINK.sel == wssp_pkg::SEL_LOW;
    assign rd_low = LINK.strobe && !LINK.write
        && LINK.sel == wssp_pkg::SEL_LOW;

    // Form of an arriving low write follows the upper words held for it.
    assign wr_form = (ext_hold != 16'h0000) ? wssp_pkg::FORM_EXT
        : (high_hold != 16'h0000) ? wssp_pkg::FORM_LONG
        : wssp_pkg::FORM_WORD;

    wssp_cmd_decode u_dec (
        .form(wr_form),
        .cmd(LINK.wdata),
        .is_clear(d_clear),
        .is_protocol(d_proto),
        .is_read_words(d_rdw),
        .is_write_data(d_wrd),
        .count(d_count)
    );

    ////////////////////////////////////////////////////////////////////
    // Write path: monitors on the data registers, write-ready flag.
    always_comb begin
        next_write_ready = write_ready;
        next_high_hold = high_hold;
        next_ext_hold = ext_hold;
        next_cmd_word = cmd_word;
        next_cmd_form = cmd_form;
        next_cmd_is_data = cmd_is_data;
        next_data_left = data_left;
        // Writes to the upper registers are held; low register completes.
        if (LINK.strobe && LINK.write && LINK.sel == wssp_pkg::SEL_HIGH
            && HAS_LONG) begin
            next_high_hold = LINK.wdata;
        end
        if (LINK.strobe && LINK.write && LINK.sel == wssp_pkg::SEL_EXT
            && HAS_EXT) begin
            next_ext_hold = LINK.wdata;
        end
        if (CMD_VALID && CMD_TAKEN) begin
            next_write_ready = 1'b1;
        end
        // The low word arrives last, so the low write is the trigger.
        if (wr_low && write_ready) begin
            next_write_ready = 1'b0;
            next_cmd_word = {ext_hold, high_hold, LINK.wdata};
            next_cmd_form = wr_form;
            next_high_hold = 16'h0000;
            next_ext_hold = 16'h0000;
            next_cmd_is_data = data_left != wssp_pkg::COUNT_ZERO;
            if (data_left != wssp_pkg::COUNT_ZERO) begin
                next_data_left = data_left - 8'h01;
            end else if (d_wrd) begin
                next_data_left = d_count;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            write_ready <= wssp_pkg::WRITE_READY_RST;
            high_hold <= 16'h0000;
            ext_hold <= 16'h0000;
            cmd_word <= 48'h000000000000;
            cmd_form <= wssp_pkg::FORM_WORD;
            cmd_is_data <= 1'b0;
            data_left <= wssp_pkg::COUNT_ZERO;
        end else begin
            write_ready <= next_write_ready;
            high_hold <= next_high_hold;
            ext_hold <= next_ext_hold;
            cmd_word <= next_cmd_word;
            cmd_form <= next_cmd_form;
            cmd_is_data <= next_cmd_is_data;
            data_left <= next_data_left;
        end
    end

    assign CMD_VALID = !write_ready;
    assign CMD_FORM = cmd_form;
    assign CMD_WORD = cmd_word;
    assign CMD_IS_DATA = cmd_is_data;

    ////////////////////////////////////////////////////////////////////
    // Read path: requested word count, read-ready flag, capability reply.
    always_comb begin
        next_read_ready = read_ready;
        next_out_left = out_left;
        next_rd_word = rd_word;
        next_cap_pending = cap_pending;
        OUT_TAKEN = 1'b0;
        // Requests come from commands accepted on the write side.
        if (wr_low && write_ready && data_left == wssp_pkg::COUNT_ZERO) begin
            if (d_rdw) begin
                next_out_left = d_count;
            end
            if (d_proto) begin
                next_cap_pending = 1'b1;
            end
        end
        if (rd_low && read_ready) begin
            next_read_ready = 1'b0;
        end else if (!read_ready && cap_pending) begin
            next_rd_word = cap_word;
            next_read_ready = 1'b1;
            next_cap_pending = 1'b0;
        end else if (!read_ready && out_left != wssp_pkg::COUNT_ZERO
            && OUT_VALID) begin
            OUT_TAKEN = 1'b1;
            next_rd_word = OUT_WORD;
            next_read_ready = 1'b1;
            next_out_left = out_left - 8'h01;
        end
        // Clear drops everything waiting on the read side.
        if (wr_low && write_ready && data_left == wssp_pkg::COUNT_ZERO
            && d_clear) begin
            next_read_ready = 1'b0;
            next_out_left = wssp_pkg::COUNT_ZERO;
            next_cap_pending = 1'b0;
            OUT_TAKEN = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            read_ready <= wssp_pkg::READ_READY_RST;
            out_left <= wssp_pkg::COUNT_ZERO;
            rd_word <= 16'h0000;
            cap_pending <= 1'b0;
        end else begin
            read_ready <= next_read_ready;
            out_left <= next_out_left;
            rd_word <= next_rd_word;
            cap_pending <= next_cap_pending;
        end
    end

    assign OUT_WANTED = !read_ready && out_left != wssp_pkg::COUNT_ZERO;

    ////////////////////////////////////////////////////////////////////
    // Bus answer: one cycle after the strobe, error on unrequested read.
    always_comb begin
        next_ack = LINK.strobe;
        next_err = rd_low && !read_ready;
        next_rdata = 16'h0000;
        if (LINK.strobe && !LINK.write) begin
            case (LINK.sel)
                wssp_pkg::SEL_LOW: next_rdata = rd_word;
                wssp_pkg::SEL_RESP: next_rdata = wssp_pkg::RESP_BASE
                    | 16'({write_ready} << wssp_pkg::RESP_WRITE_READY)
                    | 16'({read_ready} << wssp_pkg::RESP_READ_READY)
                    | 16'({1'b1} << wssp_pkg::RESP_ERROR_N);
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack <= 1'b0;
            err <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            ack <= next_ack;
            err <= next_err;
            rdata <= next_rdata;
        end
    end

    assign LINK.ack = ack;
    assign LINK.err = err;
    assign LINK.rdata = rdata;
endmodule
`default_nettype wire

// [rtl/wssp_commander.sv]
`default_nettype none
// Commander end: sends one command or data word, or fetches one word,
// polling the response register to pace each move.
module wssp_commander (
    input wire logic CLK,
    input wire logic RESET_N,
    wssp_if.commander LINK,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [1:0] REQ_FORM,
    input wire logic [47:0] REQ_WORD,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [15:0] RSP_WORD,
    output logic RSP_ERR
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_POLL = 6'b000010,
        S_WAITP = 6'b000100,
        S_UPPER = 6'b001000,
        S_LOW = 6'b010000,
        S_WAITD = 6'b100000
    } wssp_state_t;
    wssp_state_t state, next_state;
    logic write, next_write;
    logic [1:0] form, next_form, sel, next_sel;
    logic [47:0] word, next_word;
    logic strobe, next_strobe;
    logic rsp_valid, next_rsp_valid, rsp_err, next_rsp_err;
    logic [15:0] rsp_word, next_rsp_word;

    // Poll, then write upper registers first and the low register last.
    always_comb begin
        next_state = state;
        next_write = write;
        next_form = form;
        next_word = word;
        next_sel = sel;
        next_strobe = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_err = rsp_err;
        next_rsp_word = rsp_word;
        case (state)
            S_IDLE: if (REQ_VALID) begin
                next_write = REQ_WRITE;
                next_form = REQ_FORM;
                next_word = REQ_WORD;
                next_state = S_POLL;
            end
            S_POLL: begin
                next_strobe = 1'b1;
                next_sel = wssp_pkg::SEL_RESP;
                next_state = S_WAITP;
            end
            S_WAITP: if (LINK.ack && !strobe) begin
                if (write && LINK.rdata[wssp_pkg::RESP_WRITE_READY]) begin
                    next_state = (form == wssp_pkg::FORM_WORD) ? S_LOW
                        : S_UPPER;
                end else if (!write
                    && LINK.rdata[wssp_pkg::RESP_READ_READY]) begin
                    next_state = S_LOW;
                end else begin
                    next_state = S_POLL;
                end
            end
            // A cycle always passes between two strobes on the link.
            S_UPPER: if (!strobe) begin
                next_strobe = 1'b1;
                if (form == wssp_pkg::FORM_EXT
                    && sel == wssp_pkg::SEL_RESP) begin
                    next_sel = wssp_pkg::SEL_EXT;
                end else begin
                    next_sel = wssp_pkg::SEL_HIGH;
                    next_state = S_LOW;
                end
            end
            S_LOW: if (!strobe) begin
                next_strobe = 1'b1;
                next_sel = wssp_pkg::SEL_LOW;
                next_state = S_WAITD;
            end
            S_WAITD: if (LINK.ack && !strobe) begin
                next_rsp_valid = 1'b1;
                next_rsp_err = LINK.err;
                next_rsp_word = LINK.rdata;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= S_IDLE;
            write <= 1'b0;
            form <= wssp_pkg::FORM_WORD;
            word <= 48'h000000000000;
            sel <= wssp_pkg::SEL_LOW;
            strobe <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_word <= 16'h0000;
        end else begin
            state <= next_state;
            write <= next_write;
            form <= next_form;
            word <= next_word;
            sel <= next_sel;
            strobe <= next_strobe;
            rsp_valid <= next_rsp_valid;
            rsp_err <= next_rsp_err;
            rsp_word <= next_rsp_word;
        end
    end

    assign LINK.strobe = strobe;
    assign LINK.sel = sel;
    assign LINK.write = write && sel != wssp_pkg::SEL_RESP;
    assign LINK.wdata = (sel == wssp_pkg::SEL_EXT) ? word[47:32]
        : (sel == wssp_pkg::SEL_HIGH) ? word[31:16] : word[15:0];
    assign REQ_READY = state == S_IDLE;
    assign RSP_VALID = rsp_valid;
    assign RSP_WORD = rsp_word;
    assign RSP_ERR = rsp_err;
endmodule
`default_nettype wire

// [verification/wssp_link_properties.sv]
`default_nettype none
// Watches pacing and answer timing on the link between both ends.
module wssp_link_properties (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic strobe,
    input wire logic write,
    input wire logic [1:0] sel,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic err
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic resp_rd, low_rd, wr_seen, rd_seen, first;
    logic next_resp_rd, next_low_rd, next_wr_seen, next_rd_seen, next_first;
    ////////////////////////////////////////////////////////////
    // Keeps the last polled flags and the kind of cycle being answered.
    always_comb begin
        next_resp_rd = strobe && !write && sel == wssp_pkg::SEL_RESP;
        next_low_rd = strobe && !write && sel == wssp_pkg::SEL_LOW;
        next_wr_seen = wr_seen;
        next_rd_seen = rd_seen;
        next_first = first;
        if (ack && resp_rd) begin
            next_wr_seen = rdata[wssp_pkg::RESP_WRITE_READY];
            next_rd_seen = rdata[wssp_pkg::RESP_READ_READY];
            next_first = 1'b0;
        end
        if (strobe && write && sel == wssp_pkg::SEL_LOW) begin
            next_wr_seen = 1'b0;
        end
        if (next_low_rd) begin
            next_rd_seen = 1'b0;
        end
    end
    // Registers the helper state; the first poll after reset is marked.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            resp_rd <= 1'b0;
            low_rd <= 1'b0;
            wr_seen <= 1'b0;
            rd_seen <= 1'b0;
            first <= 1'b1;
        end else begin
            resp_rd <= next_resp_rd;
            low_rd <= next_low_rd;
            wr_seen <= next_wr_seen;
            rd_seen <= next_rd_seen;
            first <= next_first;
        end
    end
    ////////////////////////////////////////////////////////////
    ack_follow_a: assert property (strobe |=> ack)
        else $error("link cycle not answered next cycle");
    ack_cause_a: assert property (ack |-> $past(strobe))
        else $error("answer without a cycle");
    strobe_gap_a: assert property (strobe |=> !strobe)
        else $error("link cycles too close");
    resp_fixed_a: assert property (ack && resp_rd |->
        rdata[0] && rdata[wssp_pkg::RESP_ERROR_N] && !err)
        else $error("response register fixed bits wrong");
    write_paced_a: assert property (
        strobe && write && sel == wssp_pkg::SEL_LOW |-> wr_seen)
        else $error("low write without write ready seen");
    read_paced_a: assert property (
        strobe && !write && sel == wssp_pkg::SEL_LOW |-> rd_seen)
        else $error("low read without read ready seen");
    err_source_a: assert property (err |-> ack && low_rd)
        else $error("bus error outside a low read");
    ready_read_a: assert property (
        ack && low_rd && $past(rd_seen) |-> !err)
        else $error("bus error on a ready read");
    reset_flags_a: assert property (
        ack && resp_rd && first |-> rdata[2:1] == 2'h1)
        else $error("flags after reset wrong");
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
// Drives both ends of the link and checks what comes out of each.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, req_valid, req_write, req_ready, rsp_valid, rsp_err;
    logic cmd_valid, cmd_is_data, cmd_taken, out_valid, out_taken, out_wanted;
    logic cmd_valid_b, took, er;
    logic [1:0] req_form, cmd_form;
    logic [47:0] req_word, cmd_word, cmd_word_b;
    logic [15:0] rsp_word, out_word, rd;
    logic [50:0] ec;
    logic [17:0] ee;
    logic [50:0] exp_cmd[$];
    logic [17:0] exp_rsp[$];
    logic [15:0] loaded[$];
    int failures, checks_done, taken_cnt, data_left;
    int seed = 72073;
    wssp_if wssp_if_i ();
    wssp_if wssp_if_b_i ();
    wssp_commander wssp_commander_i (.CLK(clk), .RESET_N(reset_n),
        .LINK(wssp_if_i), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_FORM(req_form), .REQ_WORD(req_word), .REQ_READY(req_ready),
        .RSP_VALID(rsp_valid), .RSP_WORD(rsp_word), .RSP_ERR(rsp_err));
    wssp_servant wssp_servant_i (.CLK(clk), .RESET_N(reset_n),
        .LINK(wssp_if_i), .CMD_VALID(cmd_valid), .CMD_FORM(cmd_form),
        .CMD_WORD(cmd_word), .CMD_IS_DATA(cmd_is_data), .CMD_TAKEN(cmd_taken),
        .OUT_WORD(out_word), .OUT_VALID(out_valid), .OUT_TAKEN(out_taken),
        .OUT_WANTED(out_wanted));
    // Second servant faces a bench driver that breaks the pacing rules.
    wssp_servant wssp_servant_b_i (.CLK(clk), .RESET_N(reset_n),
        .LINK(wssp_if_b_i), .CMD_VALID(cmd_valid_b), .CMD_FORM(),
        .CMD_WORD(cmd_word_b), .CMD_IS_DATA(), .CMD_TAKEN(1'b0),
        .OUT_WORD(16'h0000), .OUT_VALID(1'b0), .OUT_TAKEN(), .OUT_WANTED());
    wssp_link_properties wssp_link_properties_i (.CLK(clk), .RESET_N(reset_n),
        .strobe(wssp_if_i.strobe), .write(wssp_if_i.write),
        .sel(wssp_if_i.sel), .wdata(wssp_if_i.wdata),
        .rdata(wssp_if_i.rdata), .ack(wssp_if_i.ack), .err(wssp_if_i.err));
    ////////////////////////////////////////////////////////////
    // Keeps only the part of a word that the form carries.
    function automatic logic [47:0] fmask(input logic [1:0] f);
        return f == wssp_pkg::FORM_EXT ? 48'hFFFFFFFFFFFF :
            f == wssp_pkg::FORM_LONG ? 48'h0000FFFFFFFF : 48'h00000000FFFF;
    endfunction
    task automatic check(input string what, input logic [47:0] e,
            input logic [47:0] g);
        checks_done++;
        if (e !== g) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hands one request to the commander and notes what must follow.
    task automatic send(input logic [1:0] k, input logic [1:0] f,
            input logic [47:0] w);
        int i;
        @(negedge clk);
        req_valid = 1'b1;
        req_write = k == 2'h0;
        req_form = f;
        req_word = w & fmask(f);
        i = 0;
        while (req_ready !== 1'b1 && i < 500) begin
            @(negedge clk);
            i++;
        end
        if (i >= 500) begin
            failures++;
        end
        @(posedge clk);
        if (k == 2'h0) begin
            exp_cmd.push_back({1'(data_left > 0), f, w & fmask(f)});
            if (data_left > 0) begin
                data_left--;
            end else if (f == 2'h0 && w[15:8] == wssp_pkg::OP_WRITE_DATA) begin
                data_left = int'(w[7:0]);
            end
        end
        exp_rsp.push_back({k, w[15:0]});
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] c);
        send(2'h0, wssp_pkg::FORM_WORD, {32'h0, op, c});
    endtask
    task automatic fetch(input logic [1:0] k);
        send(k, wssp_pkg::FORM_WORD, 48'h0);
    endtask
    // Waits, bounded, until all notes are used and l words are loaded.
    task automatic settle(input int l);
        int i;
        i = 0;
        while ((exp_rsp.size() + exp_cmd.size() != 0 || loaded.size() != l)
                && i < 400) begin
            @(negedge clk);
            i++;
        end
        if (i >= 400) begin
            failures++;
        end
        repeat (2) @(negedge clk);
    endtask
    // One cycle on the second link; the data lines are inverted after.
    task automatic poke(input logic w, input logic [1:0] s,
            input logic [15:0] d);
        @(negedge clk);
        wssp_if_b_i.strobe = 1'b1;
        wssp_if_b_i.write = w;
        wssp_if_b_i.sel = s;
        wssp_if_b_i.wdata = d;
        @(negedge clk);
        wssp_if_b_i.strobe = 1'b0;
        wssp_if_b_i.wdata = ~d;
        check("link answer", 48'h1, 48'(wssp_if_b_i.ack));
        rd = wssp_if_b_i.rdata;
        er = wssp_if_b_i.err;
        @(negedge clk);
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end
    // Accepts received words after a random stall and compares them.
    always @(negedge clk) begin
        if (cmd_valid === 1'b1 && ($random(seed) & 1) == 1) begin
            ec = exp_cmd.pop_front();
            cmd_taken <= 1'b1;
            check("command form", 48'(ec[49:48]), 48'(cmd_form));
            check("command word", ec[47:0],
                cmd_word & fmask(ec[49:48]));
            check("data marker", 48'(ec[50]), 48'(cmd_is_data));
        end else begin
            cmd_taken <= 1'b0;
        end
    end
    // Compares each finished transfer with the oldest note.
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            ee = exp_rsp.pop_front();
            check("response error", 48'h0, 48'(rsp_err));
            if (ee[17:16] == 2'h1) begin
                check("read word", 48'(loaded.pop_front()),
                    48'(rsp_word));
            end else if (ee[17:16] == 2'h2) begin
                check("protocol reply", 48'h3, 48'(rsp_word));
            end
        end
    end
    // Output word source; a word is held until it has been consumed.
    always @(posedge clk) begin
        if (out_taken === 1'b1) begin
            loaded.push_back(out_word);
            taken_cnt++;
            took <= 1'b1;
        end
    end
    always @(negedge clk) begin
        if (out_valid !== 1'b1 || took) begin
            out_valid <= 1'($random(seed));
            out_word <= 16'($random(seed));
        end
        took <= 1'b0;
    end
    // Main sequence of tests.
    initial begin
        reset_n = 1'b0;
        {req_valid, req_write, req_form, req_word} = '0;
        {cmd_taken, out_valid, out_word, took} = '0;
        {wssp_if_b_i.strobe, wssp_if_b_i.write} = 2'h0;
        {wssp_if_b_i.sel, wssp_if_b_i.wdata} = 18'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        cmd(wssp_pkg::OP_READ_PROTOCOL, 8'h00);
        fetch(2'h2);
        done("capability");
        for (int i = 0; i < 9; i++) begin
            send(2'h0, 2'(i % 3), {16'($random(seed)) | 16'h1,
                16'($random(seed)) | 16'h1, 16'($random(seed)) & 16'h7FFF});
        end
        done("forms");
        cmd(wssp_pkg::OP_WRITE_DATA, 8'h02);
        cmd(wssp_pkg::OP_CLEAR, 8'h00);
        cmd(wssp_pkg::OP_READ_WORDS, 8'h01);
        cmd(8'h12, 8'h34);
        done("data");
        cmd(wssp_pkg::OP_READ_WORDS, 8'h03);
        repeat (3) fetch(2'h1);
        done("multiword");
        cmd(wssp_pkg::OP_READ_WORDS, 8'h03);
        fetch(2'h1);
        settle(1);
        cmd(wssp_pkg::OP_CLEAR, 8'h00);
        settle(1);
        loaded.delete();
        check("words wanted", 48'h0, 48'(out_wanted));
        cmd(wssp_pkg::OP_READ_WORDS, 8'h01);
        fetch(2'h1);
        settle(0);
        check("words handed out", 48'h6, 48'(taken_cnt));
        done("clear");
        poke(1'b0, wssp_pkg::SEL_RESP, 16'h0);
        check("flags after reset", 48'h1, 48'(rd[2:1]));
        poke(1'b0, wssp_pkg::SEL_LOW, 16'h0);
        check("unrequested read", 48'h1, 48'(er));
        poke(1'b1, wssp_pkg::SEL_LOW, 16'h1234);
        poke(1'b1, wssp_pkg::SEL_LOW, 16'h5678);
        check("refused write", 48'h1234, cmd_word_b & 48'hFFFF);
        poke(1'b0, wssp_pkg::SEL_RESP, 16'h0);
        check("flags after write", 48'h0, 48'(rd[2:1]));
        poke(1'b0, wssp_pkg::SEL_LOW, 16'h0);
        check("read after write", 48'h1, 48'(er));
        check("word held", 48'h1, 48'(cmd_valid_b));
        done("faults");
        wrap_up();
    end
endmodule
`default_nettype wire
